// ===== include/afc_defines.svh
// Offsets, field positions, reset values and timing counts of the flow controller
`ifndef AFC_DEFINES_SVH
`define AFC_DEFINES_SVH

`define AFC_CONF_OFFSET 8'hac
`define AFC_CONF_RESET 32'h0000_0000
`define AFC_HIGH_MSB 23
`define AFC_HIGH_LSB 16
`define AFC_LOW_MSB 15
`define AFC_LOW_LSB 8
`define AFC_DUR_MSB 7
`define AFC_DUR_LSB 4
`define AFC_MULT_BIT 3
`define AFC_BRD_BIT 2
`define AFC_ADD_BIT 1
`define AFC_ANY_BIT 0
`define AFC_WR_MASK 32'h00ff_ffff
`define AFC_UNIT_SHIFT 6
`define AFC_CLK_NS 50
// Jam durations in ns; 10 Mb/s adds a fixed extra
`define AFC_DUR_EXTRA_NS 2200
`define AFC_DUR_NS(c) ((c) == 0 ? 5000 : (c) == 1 ? 10000 : \
    (c) == 2 ? 15000 : (c) == 3 ? 25000 : (c) * 50000 - 150000)
// Least time rounds up to whole cycles
`define AFC_NS_TO_CYC(ns) (((ns) + `AFC_CLK_NS - 1) / `AFC_CLK_NS)

`endif

// ===== include/afc_pkg.sv
// Types shared by the flow controller modules
package afc_pkg;
    typedef enum logic [1:0] {
        FC_IDLE,
        FC_PAUSED,
        FC_TRIGGERED
    } fc_state_t;
endpackage : afc_pkg

// ===== hdl/afc_level_cmp.sv
// Compares the receive FIFO fill against high and low thresholds
`timescale 1ns/1ps
`include "afc_defines.svh"

module afc_level_cmp #(
    parameter int CNT_W = 14
) (
    input wire logic [CNT_W-1:0] fill,
    input wire logic [7:0] hi_field,
    input wire logic [7:0] lo_field,
    output logic at_high,
    output logic below_low
);
    // Thresholds scaled to bytes; widened so 255*64 never wraps
    logic [CNT_W+8:0] hi_bytes;
    logic [CNT_W+8:0] lo_bytes;
    logic [CNT_W+8:0] fill_w;

    // --------------------------------------------------------------
    // Level compare
    // --------------------------------------------------------------
    always_comb begin
        hi_bytes = (CNT_W+9)'(hi_field) << `AFC_UNIT_SHIFT;
        lo_bytes = (CNT_W+9)'(lo_field) << `AFC_UNIT_SHIFT;
        fill_w = (CNT_W+9)'(fill);
        at_high = fill_w >= hi_bytes;
        below_low = fill_w < lo_bytes;
    end
endmodule : afc_level_cmp

// ===== hdl/afc_jam_timer.sv
// Counts out the backpressure jam time for a duration code and speed
`timescale 1ns/1ps
`include "afc_defines.svh"

module afc_jam_timer (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic start,
    input wire logic [3:0] code,
    input wire logic speed_10,
    output logic busy
);
    // --------------------------------------------------------------
    // Cycle table, one entry per code
    // --------------------------------------------------------------
    logic [15:0] cyc_100 [16];
    logic [15:0] cyc_10 [16];
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_tab
            // Built from ns so the rate change stays in one place
            assign cyc_100[g] = 16'(`AFC_NS_TO_CYC(`AFC_DUR_NS(g)));
            assign cyc_10[g] = 16'(`AFC_NS_TO_CYC(`AFC_DUR_NS(g)
                + `AFC_DUR_EXTRA_NS));
        end
    endgenerate

    typedef struct packed {
        logic [15:0] cnt;
    } jt_state_t;
    jt_state_t st_ff; // Registered state
    jt_state_t nxt_st; // Next state

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (start) begin
            // Load duration; a retrigger restarts the period
            nxt_st.cnt = speed_10 ? cyc_10[code] : cyc_100[code];
        end else if (st_ff.cnt != 16'h0) begin
            nxt_st.cnt = st_ff.cnt - 16'h1;
        end
    end

    // --------------------------------------------------------------
    // State register
    // --------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign busy = st_ff.cnt != 16'h0;

    // Jam for code 0 at 100 Mb/s lasts exactly its 100-cycle table time
    property p_jam_len;
        @(posedge REF_CLK) disable iff (!RSTN)
        start && !speed_10 && code == 4'h0
        |=> busy [*8] ##92 busy ##1 !busy;
    endproperty
    a_jam_len: assert property (p_jam_len)
        else $error("jam length wrong for code 0");
endmodule : afc_jam_timer

// ===== hdl/afc_flow_ctrl.sv
// Automatic receive flow controller: pause requests and backpressure jam
//
// What this block does
// - Nothing sent while transmitter disabled
// - High field, 64-byte units, triggers flow control
// - Full duplex: one pause per high crossing
// - Pause time comes from MAC flow register
// - Half duplex: jam matching frames for duration
// - Low field: below it send zero pause
// - Zero pause only after a real pause
// - Duration field sets jam time, half duplex
// - Duration codes map 5..600 us, +2.2 at 10M
// - Multicast enable jams multicast frames
// - Broadcast enable jams broadcast frames
// - Address enable jams own-address frames
// - Any-frame bit enables full-duplex pause
// - Any-frame half duplex acts on preamble
// - Any-frame full duplex requests pause at once
// - Any-frame overrides the three class bits
`timescale 1ns/1ps
`include "afc_defines.svh"

module afc_flow_ctrl #(
    parameter int CNT_W = 14
) (
    input wire logic REF_CLK,
    input wire logic RSTN,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic WR_EN,
    input wire logic [31:0] WR_DATA,
    output logic [31:0] RD_DATA,
    // MAC status
    input wire logic TX_ENABLED,
    input wire logic FULL_DUPLEX,
    input wire logic SPEED_10,
    input wire logic [15:0] PAUSE_TIME_VALUE,
    input wire logic [CNT_W-1:0] RX_FIFO_FILL,
    // Receive frame events, one-cycle pulses
    input wire logic RX_PREAMBLE,
    input wire logic RX_ADDR_VALID,
    input wire logic RX_IS_MULTICAST,
    input wire logic RX_IS_BROADCAST,
    input wire logic RX_IS_OWN_ADDR,
    // Pause request to MAC transmitter
    output logic PAUSE_REQ,
    output logic [15:0] PAUSE_TIME,
    input wire logic PAUSE_ACK,
    // Half-duplex jam
    output logic JAM
);
    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        logic [23:0] cfg; // Writable part of the config register
        afc_pkg::fc_state_t fc; // Full-duplex pause state
        logic req; // Pause request pending
        logic [15:0] ptime; // Pause time held with the request
    } fc_regs_t;
    fc_regs_t st_ff; // Registered state
    fc_regs_t nxt_st; // Next state

    // Field views of the config register
    logic [7:0] fifo_high_threshold;
    logic [7:0] fifo_low_threshold;
    logic [3:0] jam_duration_code;
    logic jam_on_multicast_en;
    logic jam_on_broadcast_en;
    logic jam_on_own_address_en;
    logic flow_on_any_frame_en;
    logic at_high; // Fill at or above high level
    logic below_low; // Fill below low level
    logic jam_start; // Start or restart jam timer
    logic jam_busy; // Jam period running
    logic class_hit; // Frame class matches enables
    logic auto_en; // Any flow control enabled

    assign fifo_high_threshold = st_ff.cfg[`AFC_HIGH_MSB:`AFC_HIGH_LSB];
    assign fifo_low_threshold = st_ff.cfg[`AFC_LOW_MSB:`AFC_LOW_LSB];
    assign jam_duration_code = st_ff.cfg[`AFC_DUR_MSB:`AFC_DUR_LSB];
    assign jam_on_multicast_en = st_ff.cfg[`AFC_MULT_BIT];
    assign jam_on_broadcast_en = st_ff.cfg[`AFC_BRD_BIT];
    assign jam_on_own_address_en = st_ff.cfg[`AFC_ADD_BIT];
    assign flow_on_any_frame_en = st_ff.cfg[`AFC_ANY_BIT];
    assign auto_en = st_ff.cfg[3:0] != 4'h0;

    // --------------------------------------------------------------
    // Level compare
    // --------------------------------------------------------------
    // Low below high is software's job; the compare does not enforce it
    afc_level_cmp #(
        .CNT_W(CNT_W)
    ) u_cmp (
        .fill(RX_FIFO_FILL),
        .hi_field(fifo_high_threshold),
        .lo_field(fifo_low_threshold),
        .at_high(at_high),
        .below_low(below_low)
    );

    // --------------------------------------------------------------
    // Frame class filter
    // --------------------------------------------------------------
    always_comb begin
        if (flow_on_any_frame_en) begin
            // No address decode: act on preamble, class bits ignored
            class_hit = RX_PREAMBLE;
        end else begin
            class_hit = RX_ADDR_VALID && (
                (jam_on_multicast_en && RX_IS_MULTICAST) ||
                (jam_on_broadcast_en && RX_IS_BROADCAST) ||
                (jam_on_own_address_en && RX_IS_OWN_ADDR));
        end
    end

    // Jam only in half duplex with transmitter up
    assign jam_start = !FULL_DUPLEX && TX_ENABLED && at_high
        && class_hit;

    afc_jam_timer u_jam (
        .REF_CLK(REF_CLK),
        .RSTN(RSTN),
        .start(jam_start),
        .code(jam_duration_code),
        .speed_10(SPEED_10),
        .busy(jam_busy)
    );

    // --------------------------------------------------------------
    // Next state: register writes and pause sequencing
    // --------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (WR_EN && ADDR == `AFC_CONF_OFFSET) begin
            // Top byte dropped on write
            nxt_st.cfg = WR_DATA[23:0];
        end
        // Request clears when MAC takes it
        if (st_ff.req && PAUSE_ACK) begin
            nxt_st.req = 1'b0;
        end
        // Transmitter off drops any pending request
        if (!TX_ENABLED) begin
            nxt_st.req = 1'b0;
        end
        unique case (st_ff.fc)
            afc_pkg::FC_IDLE: begin
                // Any-frame bit is what enables full-duplex pause
                if (FULL_DUPLEX && TX_ENABLED && flow_on_any_frame_en
                    && at_high) begin
                    nxt_st.req = 1'b1;
                    nxt_st.ptime = PAUSE_TIME_VALUE;
                    nxt_st.fc = afc_pkg::FC_TRIGGERED;
                end
            end
            afc_pkg::FC_TRIGGERED: begin
                // Wait for the MAC to accept the single pause
                if (st_ff.req && PAUSE_ACK) begin
                    nxt_st.fc = afc_pkg::FC_PAUSED;
                end else if (!TX_ENABLED) begin
                    // Never sent, so no resume is owed
                    nxt_st.fc = afc_pkg::FC_IDLE;
                end
            end
            afc_pkg::FC_PAUSED: begin
                // Stay silent while above low; resume once below
                if (below_low && auto_en && TX_ENABLED) begin
                    nxt_st.req = 1'b1;
                    nxt_st.ptime = 16'h0000;
                    nxt_st.fc = afc_pkg::FC_IDLE;
                end
            end
        endcase
    end

    // --------------------------------------------------------------
    // State register
    // --------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_ff <= '{cfg: 24'h0, fc: afc_pkg::FC_IDLE, req: 1'b0,
                ptime: 16'h0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign PAUSE_REQ = st_ff.req;
    assign PAUSE_TIME = st_ff.ptime;
    assign JAM = jam_busy && TX_ENABLED;
    // Reserved byte reads zero; other offsets read zero
    assign RD_DATA = (ADDR == `AFC_CONF_OFFSET) ? {8'h00, st_ff.cfg}
        : 32'h0;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    property p_no_pause_tx_off;
        @(posedge REF_CLK) disable iff (!RSTN)
        !TX_ENABLED |=> !PAUSE_REQ;
    endproperty
    a_no_pause_tx_off: assert property (p_no_pause_tx_off)
        else $error("pause requested with transmitter off");

    property p_no_jam_tx_off;
        @(posedge REF_CLK) disable iff (!RSTN)
        !TX_ENABLED |-> !JAM;
    endproperty
    a_no_jam_tx_off: assert property (p_no_jam_tx_off)
        else $error("jam with transmitter off");

    property p_pause_on_high;
        @(posedge REF_CLK) disable iff (!RSTN)
        st_ff.fc == afc_pkg::FC_IDLE && FULL_DUPLEX && TX_ENABLED
        && flow_on_any_frame_en && at_high |=> PAUSE_REQ;
    endproperty
    a_pause_on_high: assert property (p_pause_on_high)
        else $error("no pause request at high level");

    property p_single_pause;
        @(posedge REF_CLK) disable iff (!RSTN)
        PAUSE_REQ && PAUSE_ACK && PAUSE_TIME != 16'h0
        |=> !PAUSE_REQ [*2];
    endproperty
    a_single_pause: assert property (p_single_pause)
        else $error("pause repeated after acceptance");

    property p_pause_time_src;
        @(posedge REF_CLK) disable iff (!RSTN)
        $rose(PAUSE_REQ) && st_ff.fc == afc_pkg::FC_TRIGGERED
        |-> PAUSE_TIME == $past(PAUSE_TIME_VALUE);
    endproperty
    a_pause_time_src: assert property (p_pause_time_src)
        else $error("pause time not from MAC flow register");

    property p_resume_only_after;
        @(posedge REF_CLK) disable iff (!RSTN)
        $rose(PAUSE_REQ) && PAUSE_TIME == 16'h0
        |-> $past(st_ff.fc) == afc_pkg::FC_PAUSED;
    endproperty
    a_resume_only_after: assert property (p_resume_only_after)
        else $error("zero pause without prior pause");

    property p_jam_half_only;
        @(posedge REF_CLK) disable iff (!RSTN)
        FULL_DUPLEX && !jam_busy |=> !jam_busy;
    endproperty
    a_jam_half_only: assert property (p_jam_half_only)
        else $error("jam started in full duplex");

    property p_reserved_zero;
        @(posedge REF_CLK) disable iff (!RSTN)
        RD_DATA[31:24] == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

    property p_any_jam;
        @(posedge REF_CLK) disable iff (!RSTN)
        !FULL_DUPLEX && TX_ENABLED && flow_on_any_frame_en && at_high
        && RX_PREAMBLE |=> jam_busy;
    endproperty
    a_any_jam: assert property (p_any_jam)
        else $error("no jam on preamble in any-frame mode");

    // A queued pause waits for the MAC's transmit window
    property p_req_held;
        @(posedge REF_CLK) disable iff (!RSTN)
        PAUSE_REQ && !PAUSE_ACK && TX_ENABLED |=> PAUSE_REQ;
    endproperty
    a_req_held: assert property (p_req_held)
        else $error("pause request dropped before acceptance");

    property p_class_any;
        @(posedge REF_CLK) disable iff (!RSTN)
        flow_on_any_frame_en && !RX_PREAMBLE |-> !class_hit;
    endproperty
    a_class_any: assert property (p_class_any)
        else $error("class bits acted in any-frame mode");

    property p_mcast_jam;
        @(posedge REF_CLK) disable iff (!RSTN)
        !FULL_DUPLEX && TX_ENABLED && at_high && !flow_on_any_frame_en
        && jam_on_multicast_en && RX_ADDR_VALID && RX_IS_MULTICAST
        |=> jam_busy;
    endproperty
    a_mcast_jam: assert property (p_mcast_jam)
        else $error("no jam on multicast frame");

    property p_bcast_jam;
        @(posedge REF_CLK) disable iff (!RSTN)
        !FULL_DUPLEX && TX_ENABLED && at_high && !flow_on_any_frame_en
        && jam_on_broadcast_en && RX_ADDR_VALID && RX_IS_BROADCAST
        |=> jam_busy;
    endproperty
    a_bcast_jam: assert property (p_bcast_jam)
        else $error("no jam on broadcast frame");

    property p_own_jam;
        @(posedge REF_CLK) disable iff (!RSTN)
        !FULL_DUPLEX && TX_ENABLED && at_high && !flow_on_any_frame_en
        && jam_on_own_address_en && RX_ADDR_VALID && RX_IS_OWN_ADDR
        |=> jam_busy;
    endproperty
    a_own_jam: assert property (p_own_jam)
        else $error("no jam on own-address frame");

    property p_resume_on_low;
        @(posedge REF_CLK) disable iff (!RSTN)
        st_ff.fc == afc_pkg::FC_PAUSED && below_low && auto_en
        && TX_ENABLED |=> PAUSE_REQ && PAUSE_TIME == 16'h0000;
    endproperty
    a_resume_on_low: assert property (p_resume_on_low)
        else $error("no zero pause below low level");

    property p_cfg_write;
        @(posedge REF_CLK) disable iff (!RSTN)
        WR_EN && ADDR == `AFC_CONF_OFFSET
        |=> st_ff.cfg == $past(WR_DATA[23:0]);
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("config write did not land");
endmodule : afc_flow_ctrl

// ===== bench/link_partner.sv
// Remote station model: sends frame events, takes pause requests
`timescale 1ns/1ps

module link_partner (
    input wire logic clk,
    input wire logic pause_req,
    input wire logic [15:0] pause_time,
    output logic preamble,
    output logic addr_valid,
    output logic is_mcast,
    output logic is_bcast,
    output logic is_own,
    output logic pause_ack
);
    int n_pause = 0; // Pause frames taken
    int ack_delay = 0; // Slow partner when above zero
    logic [15:0] last_time = 16'h0; // Time of last pause
    bit paused = 0; // Own traffic held while set

    // ----------------------------------------
    // Pause handshake, request held till ack
    // ----------------------------------------
    initial begin
        {preamble, addr_valid, is_mcast, is_bcast, is_own} = 5'h00;
        pause_ack = 1'b0;
        forever begin
            @(posedge clk);
            if (pause_req === 1'b1) begin
                repeat (ack_delay) @(posedge clk);
                #1 pause_ack = 1'b1;
                @(posedge clk);
                last_time = pause_time;
                n_pause++;
                // Zero time resumes traffic at once
                paused = (pause_time != 16'h0);
                #1 pause_ack = 1'b0;
                @(posedge clk);
            end
        end
    end

    // Preamble pulse, entered just after an edge
    task automatic start_frame();
        // Own traffic waits while a non-zero pause is in force
        while (paused) begin
            @(posedge clk);
            #1;
        end
        preamble = 1'b1;
        @(posedge clk);
        #1 preamble = 1'b0;
    endtask : start_frame

    // Address decode pulse; 1 own, 2 broadcast, 3 multicast
    task automatic send_addr(input int k);
        addr_valid = 1'b1;
        {is_mcast, is_bcast, is_own} = {k == 3, k == 2, k == 1};
        @(posedge clk);
        #1 addr_valid = 1'b0;
        // Released lines flip so a stale class never matches
        {is_mcast, is_bcast, is_own} = ~{is_mcast, is_bcast, is_own};
    endtask : send_addr
endmodule : link_partner

// ===== bench/tb.sv
// Self-checking bench for the automatic flow controller
`timescale 1ns/1ps

module tb;
    logic ref_clk, rstn, wr_en, tx_en, fd, s10; // Clock and MAC status
    logic [7:0] addr; // Register address
    logic [31:0] wr_data, rd_data; // Register data
    logic [13:0] fill; // FIFO fill in bytes
    logic [15:0] ptv, ptime; // Pause times in and out
    logic pre, av, is_m, is_b, is_o, preq, pack, jam; // Frame and flow
    int n_mismatch = 0;
    int checks_done = 0;

    afc_flow_ctrl dut (
        .REF_CLK(ref_clk), .RSTN(rstn), .ADDR(addr), .WR_EN(wr_en),
        .WR_DATA(wr_data), .RD_DATA(rd_data), .TX_ENABLED(tx_en),
        .FULL_DUPLEX(fd), .SPEED_10(s10), .PAUSE_TIME_VALUE(ptv),
        .RX_FIFO_FILL(fill), .RX_PREAMBLE(pre), .RX_ADDR_VALID(av),
        .RX_IS_MULTICAST(is_m), .RX_IS_BROADCAST(is_b),
        .RX_IS_OWN_ADDR(is_o), .PAUSE_REQ(preq), .PAUSE_TIME(ptime),
        .PAUSE_ACK(pack), .JAM(jam)
    );
    link_partner partner (
        .clk(ref_clk), .pause_req(preq), .pause_time(ptime),
        .preamble(pre), .addr_valid(av), .is_mcast(is_m),
        .is_bcast(is_b), .is_own(is_o), .pause_ack(pack)
    );

    // --------------------
    // Helpers
    // --------------------
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Always leaves the bench 1 ns after an edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr = a;
        wr_data = d;
        wr_en = 1'b1;
        tick(1);
        wr_en = 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        addr = a;
        tick(1);
        chk(rd_data, exp);
    endtask : rd_chk

    // High 256 bytes, low 128 bytes, low kept under high
    task automatic cfg(input logic [3:0] code, input logic [3:0] bits);
        wr(8'hac, {8'h00, 8'h04, 8'h02, code, bits});
    endtask : cfg

    // Counts jam cycles, bounded past the longest code
    task automatic count_jam(output int n);
        n = 0;
        while (jam === 1'b1 && n < 13000) begin
            n++;
            tick(1);
        end
    endtask : count_jam

    function automatic int jam_cyc(input int c, input bit slow);
        int us;
        us = (c < 4) ? (c == 3 ? 25 : 5 * (c + 1)) : c * 50 - 150;
        return (us * 1000 + (slow ? 2200 : 0) + 49) / 50;
    endfunction : jam_cyc

    // --------------------
    // Scenarios
    // --------------------
    task automatic test_regs();
        rd_chk(8'hac, 32'h0);
        wr(8'hac, 32'hffff_ffff);
        rd_chk(8'hac, 32'h00ff_ffff);
        wr(8'ha8, 32'h0);
        rd_chk(8'hac, 32'h00ff_ffff);
        rd_chk(8'ha8, 32'h0);
        wr(8'hac, 32'h0);
        rd_chk(8'hac, 32'h0);
    endtask : test_regs

    task automatic test_tx_off();
        int n;
        fd = 1'b1;
        cfg(4'h0, 4'h1);
        fill = 14'd300;
        tick(10);
        chk(partner.n_pause, 0);
        fd = 1'b0;
        partner.start_frame();
        chk(jam, 1'b0);
        fill = 14'd0;
        tx_en = 1'b1;
        tick(1);
        count_jam(n);
        chk(n, 0);
    endtask : test_tx_off

    task automatic test_fd_pause();
        fd = 1'b1;
        cfg(4'h0, 4'h8);
        fill = 14'd300;
        partner.start_frame();
        tick(1);
        partner.send_addr(3);
        chk(jam, 1'b0);
        tick(10);
        chk(partner.n_pause, 0);
        fill = 14'd0;
        cfg(4'h0, 4'h1);
        fill = 14'd255;
        tick(10);
        chk(partner.n_pause, 0);
        fill = 14'd256;
        tick(1);
        chk(preq, 1'b1);
        chk(ptime, 16'h1234);
        tick(20);
        chk(partner.n_pause, 1);
        fill = 14'd128;
        tick(10);
        chk(partner.n_pause, 1);
        partner.ack_delay = 5;
        fill = 14'd127;
        tick(15);
        chk(partner.n_pause, 2);
        chk(partner.last_time, 16'h0);
        tick(20);
        chk(partner.n_pause, 2);
        fill = 14'd0;
    endtask : test_fd_pause

    // Every duration code at 100 Mb/s, the short ones at 10 Mb/s
    task automatic test_hd_codes();
        int n;
        fd = 1'b0;
        fill = 14'd300;
        for (int s = 0; s < 2; s++) begin
            s10 = s[0];
            for (int c = 0; c < (s == 0 ? 16 : 4); c++) begin
                cfg(c[3:0], 4'h1);
                partner.start_frame();
                count_jam(n);
                chk(n, jam_cyc(c, s[0]));
            end
        end
        s10 = 1'b0;
    endtask : test_hd_codes

    task automatic test_hd_class();
        int n;
        for (int b = 1; b < 4; b++) begin
            for (int k = 1; k < 4; k++) begin
                cfg(4'h0, 4'h1 << b);
                partner.start_frame();
                chk(jam, 1'b0);
                tick(1);
                partner.send_addr(k);
                chk(jam, b == k);
                count_jam(n);
            end
        end
        cfg(4'h0, 4'h9);
        partner.start_frame();
        chk(jam, 1'b1);
        count_jam(n);
        partner.send_addr(3);
        chk(jam, 1'b0);
        fill = 14'd255;
        partner.start_frame();
        chk(jam, 1'b0);
    endtask : test_hd_class

    task automatic print_verdict();
        $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // --------------------
    // Main sequence and watchdog
    // --------------------
    initial begin
        {rstn, wr_en, tx_en, fd, s10} = 5'h00;
        addr = 8'hac;
        wr_data = 32'h0;
        fill = 14'd0;
        ptv = 16'h1234;
        repeat (6) @(posedge ref_clk);
        #1 rstn = 1'b1;
        test_regs();
        test_tx_off();
        test_fd_pause();
        test_hd_codes();
        test_hd_class();
        print_verdict();
    end

    // Run needs about 81000 cycles
    initial begin
        repeat (95000) @(posedge ref_clk);
        n_mismatch++;
        print_verdict();
    end
endmodule : tb
